// >>> shared/standby_pkg.sv
/*
  constants, types and register map of the halt standby controller.
  assumes a single 100 MHz clock and an AXI4-Lite register port.
*/
package standby_pkg;
  localparam logic [3:0] ctrl_offset = 4'h0;
  localparam logic [3:0] idle_run_offset = 4'h4;
  localparam logic [3:0] status_offset = 4'h8;

  localparam logic [1:0] halt_mode_reserved = 2'h0;
  localparam logic [1:0] halt_mode_stop = 2'h1;
  localparam logic [1:0] halt_mode_deep = 2'h2;
  localparam logic [1:0] halt_mode_light = 2'h3;

  localparam logic [1:0] warmup_2p8 = 2'h1;
  localparam logic [1:0] warmup_2p14 = 2'h2;
  localparam logic [1:0] warmup_2p16 = 2'h3;
  localparam int warmup_cycles_2p8 = 256;

  localparam logic [1:0] ctrl_halt_mode_reset = halt_mode_light;
  localparam logic [1:0] ctrl_warmup_reset = warmup_2p14;
  localparam int idle_run_width = 18;
  localparam logic [17:0] idle_run_reset = 18'h00000;
  localparam int idle_run_wdt_bit = 17;
  localparam int ext_int_count = 12;

  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [2:0] {
    st_run = 3'b000,
    st_light_idle = 3'b001,
    st_deep_idle = 3'b010,
    st_stop = 3'b011,
    st_warmup = 3'b100
  } standby_state_type;
endpackage

// >>> logic/halt_standby_controller.sv
/*
  halt standby controller: three halt modes entered on the sleep instruction,
  release by interrupt, key wake-up or reset, oscillator warm-up after stop.
  assumes the cpu pulses sleep_exec for one cycle and that interrupt requests
  and priorities arrive as levels synchronous to mclk; mclk itself never stops.
*/
// Chosen here: the register addresses and register access over AXI4-Lite.
// Contract
// - sleep instruction enters mode by select field: 11 light, 10 deep, 01 stop.
// - light idle halts cpu; peripherals run only when their own enable set.
// - light idle holds i/o ports at their state at the sleep instruction.
// - deep idle stops system clock; only oscillator and clock timer run.
// - stop halts every internal circuit, oscillator included.
// - interrupt above priority mask releases halt and is serviced.
// - maskable interrupt below the mask does not release, except external 0-7; the code excepts only 0-7 on port pins, not 4-7 as timer inputs.
// - non-maskable interrupt releases and is serviced regardless of the mask.
// - masked external 0-7 request releases without service; its flag stays set. The code does so only for 0-7 on port pins, not 4-7 as timer inputs.
// - reset releases every halt; all settings return to reset values.
// - release by interrupt leaves all settings unchanged.
// - leaving stop by wake source restarts clock after programmed warm-up.
// - nmi, external 0-7 and key wake-ups from stop act after warm-up.
// - key wake-up releases any halt, no interrupt, resumes after sleep.
// - requests sampled during halt; restart is synchronous to the clock.
// - external 4-B as timer inputs release light idle only.
`timescale 1ns/100ps
`default_nettype none
module halt_standby_controller
  #(parameter int warmup_cycles_2p14 = 16384,
    parameter int warmup_cycles_2p16 = 65536) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_exec,
  input wire logic [2:0] cpu_priority_mask,
  input wire logic nmi_req,
  input wire logic key_wakeup_input,
  input wire logic watchdog_interrupt,
  input wire logic [2:0] watchdog_prio,
  input wire logic periph_int_req,
  input wire logic [2:0] periph_int_prio,
  input wire logic [11:0] ext_int_req,
  input wire logic [11:0][2:0] ext_int_prio,
  input wire logic [11:4] ext_int_timer_cfg,
  output logic cpu_halt,
  output logic sysclk_run,
  output logic osc_run,
  output logic clock_timer_run,
  output logic port_hold,
  output logic [17:0] periph_run,
  output logic wake_service,
  output logic wake_resume
);
  import standby_pkg::*;

  typedef struct packed {
    standby_state_type state;
    logic [1:0] halt_mode_select;
    logic [1:0] warmup_time_select;
    logic [17:0] idle_run;
    logic [16:0] warm_cnt;
    logic warm_service;
    logic last_service;
    logic last_resume;
    logic last_warm;
    logic svc_pulse;
    logic res_pulse;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctl_type;

  ctl_type cur_reg;
  ctl_type cur_next;

  // priority zero makes a maskable source masked; mask seven masks all of them
  function automatic logic above_mask(input logic [2:0] prio, input logic [2:0] mask);
    above_mask = (prio != 3'h0) && (prio > mask);
  endfunction

  function automatic logic mapped(input logic [3:0] addr);
    mapped = (addr == ctrl_offset) || (addr == idle_run_offset) || (addr == status_offset);
  endfunction

  function automatic logic [16:0] warmup_count(input logic [1:0] sel);
    unique case (sel)
      warmup_2p16: warmup_count = 17'(warmup_cycles_2p16);
      warmup_2p14: warmup_count = 17'(warmup_cycles_2p14);
      default: warmup_count = 17'(warmup_cycles_2p8);
    endcase
  endfunction

  logic svc_req;
  logic res_req;
  logic light;

  // wake decode, sampled every cycle while halted
  always_comb begin
    logic port_cfg;
    logic enabled;
    port_cfg = 1'b1;
    enabled = 1'b0;
    light = (cur_reg.state == st_light_idle);
    svc_req = nmi_req;
    res_req = key_wakeup_input;
    if (light) begin
      svc_req = svc_req | (watchdog_interrupt & above_mask(watchdog_prio, cpu_priority_mask));
      svc_req = svc_req | (periph_int_req & above_mask(periph_int_prio, cpu_priority_mask));
    end
    for (int i = 0; i < ext_int_count; i++) begin
      port_cfg = (i < 4) ? 1'b1 : !ext_int_timer_cfg[i];
      enabled = above_mask(ext_int_prio[i], cpu_priority_mask);
      if (ext_int_req[i] && enabled) begin
        // timer inputs and 8-b only wake light idle
        if (light || (port_cfg && i < 8)) begin
          svc_req = 1'b1;
        end
      end
      // masked 0-7 on port pins resume without service
      if (ext_int_req[i] && !enabled && port_cfg && i < 8) begin
        res_req = 1'b1;
      end
    end
  end

  always_comb begin
    logic [31:0] wmask;
    cur_next = cur_reg;
    wmask = {{8{cur_reg.w_strb[3]}}, {8{cur_reg.w_strb[2]}},
             {8{cur_reg.w_strb[1]}}, {8{cur_reg.w_strb[0]}}};
    cur_next.svc_pulse = 1'b0;
    cur_next.res_pulse = 1'b0;

    unique case (cur_reg.state)
      st_run: begin
        if (sleep_exec) begin
          unique case (cur_reg.halt_mode_select)
            halt_mode_light: cur_next.state = st_light_idle;
            halt_mode_deep: cur_next.state = st_deep_idle;
            halt_mode_stop: cur_next.state = st_stop;
            halt_mode_reserved: cur_next.state = st_run;
          endcase
        end
      end
      st_light_idle, st_deep_idle: begin
        // settings untouched on interrupt release
        if (svc_req || res_req) begin
          cur_next.state = st_run;
          cur_next.svc_pulse = svc_req;
          cur_next.res_pulse = !svc_req;
          cur_next.last_service = svc_req;
          cur_next.last_resume = !svc_req;
          cur_next.last_warm = 1'b0;
        end
      end
      st_stop: begin
        if (svc_req || res_req) begin
          cur_next.state = st_warmup;
          cur_next.warm_service = svc_req;
          cur_next.warm_cnt = warmup_count(cur_reg.warmup_time_select);
        end
      end
      st_warmup: begin
        // clock held off until the count expires
        if (cur_reg.warm_cnt <= 17'h00001) begin
          cur_next.state = st_run;
          cur_next.svc_pulse = cur_reg.warm_service;
          cur_next.res_pulse = !cur_reg.warm_service;
          cur_next.last_service = cur_reg.warm_service;
          cur_next.last_resume = !cur_reg.warm_service;
          cur_next.last_warm = 1'b1;
        end else begin
          cur_next.warm_cnt = cur_reg.warm_cnt - 17'h00001;
        end
      end
      default: cur_next.state = st_run;
    endcase

    // write channel: address and data taken in either order
    if (s_axi_awvalid && !cur_reg.aw_held) begin
      cur_next.aw_held = 1'b1;
      cur_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur_reg.w_held) begin
      cur_next.w_held = 1'b1;
      cur_next.w_data = s_axi_wdata;
      cur_next.w_strb = s_axi_wstrb;
    end
    if (cur_reg.aw_held && cur_reg.w_held && !cur_reg.bvalid) begin
      cur_next.aw_held = 1'b0;
      cur_next.w_held = 1'b0;
      cur_next.bvalid = 1'b1;
      cur_next.bresp = mapped(cur_reg.aw_addr) ? resp_okay : resp_slverr;
      if (cur_reg.aw_addr == ctrl_offset) begin
        if (cur_reg.w_strb[0]) begin
          cur_next.halt_mode_select = cur_reg.w_data[1:0];
          cur_next.warmup_time_select = cur_reg.w_data[3:2];
        end
      end else if (cur_reg.aw_addr == idle_run_offset) begin
        cur_next.idle_run = (cur_reg.idle_run & ~wmask[17:0]) | (cur_reg.w_data[17:0] & wmask[17:0]);
      end
    end
    if (cur_reg.bvalid && s_axi_bready) begin
      cur_next.bvalid = 1'b0;
    end

    if (s_axi_arvalid && !cur_reg.rvalid) begin
      cur_next.rvalid = 1'b1;
      cur_next.rresp = mapped(s_axi_araddr) ? resp_okay : resp_slverr;
      unique case (s_axi_araddr)
        ctrl_offset: cur_next.rdata = {28'h0000000, cur_reg.warmup_time_select,
                                       cur_reg.halt_mode_select};
        idle_run_offset: cur_next.rdata = {14'h0000, cur_reg.idle_run};
        status_offset: cur_next.rdata = {25'h0000000, cur_reg.last_warm, cur_reg.last_resume,
                                         cur_reg.last_service, 1'b0, cur_reg.state};
        default: cur_next.rdata = 32'h00000000;
      endcase
    end else if (cur_reg.rvalid && s_axi_rready) begin
      cur_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cur_reg <= '0;
      cur_reg.state <= st_run;
      cur_reg.halt_mode_select <= ctrl_halt_mode_reset;
      cur_reg.warmup_time_select <= ctrl_warmup_reset;
      cur_reg.idle_run <= idle_run_reset;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign s_axi_awready = !cur_reg.aw_held;
  assign s_axi_wready = !cur_reg.w_held;
  assign s_axi_bvalid = cur_reg.bvalid;
  assign s_axi_bresp = cur_reg.bresp;
  assign s_axi_arready = !cur_reg.rvalid;
  assign s_axi_rvalid = cur_reg.rvalid;
  assign s_axi_rdata = cur_reg.rdata;
  assign s_axi_rresp = cur_reg.rresp;

  assign cpu_halt = (cur_reg.state != st_run);
  // deep idle and stop gate the system clock
  assign sysclk_run = (cur_reg.state == st_run) || (cur_reg.state == st_light_idle);
  // oscillator restarts on wake so it can settle during warm-up
  assign osc_run = (cur_reg.state != st_stop);
  assign clock_timer_run = (cur_reg.state != st_stop) && (cur_reg.state != st_warmup);
  assign port_hold = (cur_reg.state == st_light_idle);
  assign periph_run = (cur_reg.state == st_run) ? {idle_run_width{1'b1}} :
                      (cur_reg.state == st_light_idle) ? cur_reg.idle_run :
                      {idle_run_width{1'b0}};
  assign wake_service = cur_reg.svc_pulse;
  assign wake_resume = cur_reg.res_pulse;
endmodule
`default_nettype wire

// >>> tb/halt_standby_properties.sv
/* checker for the standby controller outputs.
   bound into halt_standby_controller and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module halt_standby_properties (
  input wire logic mclk, rst_b, cpu_halt, sysclk_run, osc_run, clock_timer_run,
  input wire logic port_hold, wake_service, wake_resume, nmi_req, key_wakeup_input,
  input wire logic [17:0] periph_run,
  input wire logic [11:0] ext_int_req
);
  // mode decoded from the clock outputs, warm-up has the oscillator back
  wire lt = cpu_halt & sysclk_run;
  wire dp = cpu_halt & osc_run & clock_timer_run & !sysclk_run;
  wire wu = cpu_halt & osc_run & !clock_timer_run;
  wire st = !osc_run;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  AST_STOP_OFF: assert property (
    st |-> cpu_halt && !sysclk_run && !clock_timer_run && periph_run == '0) else $error("stop");
  AST_DEEP_OFF: assert property (
    dp |-> periph_run == '0 && !port_hold) else $error("deep idle outputs");
  AST_LIGHT_HOLD: assert property (
    lt |-> port_hold) else $error("ports not held");
  AST_RUN_ALL: assert property (
    !cpu_halt |-> &periph_run && sysclk_run && !port_hold) else $error("run outputs");
  AST_NMI_WAKE: assert property (
    (lt || dp) && nmi_req |=> wake_service && !cpu_halt) else $error("nmi release");
  AST_KEY_WAKE: assert property (
    dp && key_wakeup_input |=> !cpu_halt && (wake_service || wake_resume)) else $error("key");
  AST_DEEP_IGNORE: assert property (
    dp && !nmi_req && !key_wakeup_input && ext_int_req == '0 |=> cpu_halt) else $error("deep");
  AST_STOP_WARM: assert property (
    st && (nmi_req || key_wakeup_input) |=> wu) else $error("no warm-up");
  AST_WARM_LEN: assert property (
    $rose(wu) |-> wu[*8] ##1 wu[*8]) else $error("warm-up too short");
  AST_WAKE_PULSE: assert property (
    wake_service || wake_resume |-> !cpu_halt && $past(cpu_halt)) else $error("stray pulse");
endmodule
bind halt_standby_controller halt_standby_properties i_props (.*);
`default_nettype wire

// >>> tb/wake_source_model.sv
/* wake sources and cpu side beside the controller.
   assumes one source fired at a time by the bench, cleared by clr. */
`timescale 1ns/100ps
`default_nettype none
module wake_source_model (
  input wire logic mclk, rst_b, fire, clr, wake_service,
  input wire logic [2:0] src,
  output logic nmi_req, key_wakeup_input, periph_int_req, watchdog_interrupt,
  output logic [11:0] ext_int_req
);
  // src 0-6: nmi, key, peripheral, watchdog, external 0, 4 and 8
  logic [6:0] req_reg = '0;
  assign {watchdog_interrupt, periph_int_req, key_wakeup_input, nmi_req} = req_reg[3:0];
  assign ext_int_req = {3'h0, req_reg[6], 3'h0, req_reg[5], 3'h0, req_reg[4]};
  always @(posedge mclk)
    if (!rst_b || clr) req_reg <= '0;
    else if (fire) req_reg <= 7'h01 << src;
    // level kept until servicing starts; a resume leaves the flag up
    else if (wake_service) req_reg <= '0;
endmodule
`default_nettype wire

// >>> tb/test_halt_standby_controller.sv
/* self-checking bench of the standby controller over AXI4-Lite.
   assumes the wake source model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module test_halt_standby_controller;
  import standby_pkg::*;
  logic mclk = 0, rst_b = 0, sleep_exec = 0, fire = 0, clr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [2:0] cpu_priority_mask = 3'h3, watchdog_prio = '0, periph_int_prio = '0, src = '0;
  logic [11:0][2:0] ext_int_prio = '0;
  // external 4 as timer input, 8 stays a port pin
  logic [11:4] ext_int_timer_cfg = 8'h01;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_rvalid, cpu_halt, sysclk_run, osc_run, clock_timer_run, port_hold;
  logic wake_service, wake_resume, nmi_req, key_wakeup_input, watchdog_interrupt, periph_int_req;
  logic [11:0] ext_int_req;
  logic [17:0] periph_run, ir = '0;
  int miscompares = 0, check_count = 0, seed = 32'hd753;
  localparam int warm_test = 20;
  halt_standby_controller #(.warmup_cycles_2p14(warm_test), .warmup_cycles_2p16(30)) i_dut (.*);
  wake_source_model i_src (.*);
  always #5 mclk = ~mclk;
  task end_sim;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [3:0] lvl(input logic [1:0] m);
    return m == halt_mode_light ? 4'hf : m == halt_mode_deep ? 4'h6 : 4'h0;
  endfunction
  task rst;
    rst_b <= 0;
    repeat (5) @(posedge mclk);
    rst_b <= 1;
    ir = '0;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa, pw;
    pa = 1;
    pw = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    // each channel released at its own ready
    do begin
      @(posedge mclk);
      pa = pa & !s_axi_awready;
      pw = pw & !s_axi_wready;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end while (pa | pw);
    do @(posedge mclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 0;
    chk(s_axi_bresp, r);
    // let an edge pass so the next call never re-drives bready in this step
    @(posedge mclk);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge mclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
    @(posedge mclk);
  endtask
  // n: edges until the halt drops, 60 when the source must not release
  task hw(input logic [1:0] m, input logic [2:0] s, p, input int n, input logic [1:0] e);
    int k;
    ir = 18'($random(seed)) | 18'h00001;
    wr(idle_run_offset, {14'h0, ir}, resp_okay);
    wr(ctrl_offset, {28'h0, 2'h2, m}, resp_okay);
    periph_int_prio <= p;
    watchdog_prio <= p;
    ext_int_prio[0] <= p;
    ext_int_prio[4] <= p;
    ext_int_prio[8] <= p;
    sleep_exec <= 1;
    @(posedge mclk);
    sleep_exec <= 0;
    @(posedge mclk);
    chk(cpu_halt, 1);
    chk({sysclk_run, osc_run, clock_timer_run, port_hold}, lvl(m));
    chk(periph_run, m == halt_mode_light ? ir : '0);
    src <= s;
    fire <= 1;
    @(posedge mclk);
    fire <= 0;
    for (k = 0; k < 60 && cpu_halt === 1'h1; k++) @(posedge mclk);
    chk(k, n);
    chk({wake_service, wake_resume}, e);
    if (n == 60) rst;
    rd(ctrl_offset, n == 60 ? {28'h0, ctrl_warmup_reset, ctrl_halt_mode_reset} : {2'h2, m},
       resp_okay);
    rd(idle_run_offset, {14'h0, ir}, resp_okay);
    rd(status_offset, n == 60 ? '0 : {25'h0, m == halt_mode_stop, e[0], e[1], 4'h0},
       resp_okay);
    clr <= 1;
    @(posedge mclk);
    clr <= 0;
  endtask
  initial begin
    rst;
    rd(status_offset, '0, resp_okay);
    rd(4'hc, '0, resp_slverr);
    wr(4'hc, '1, resp_slverr);
    // reserved select: the sleep instruction must leave the cpu running
    wr(ctrl_offset, {28'h0, 2'h2, halt_mode_reserved}, resp_okay);
    sleep_exec <= 1;
    @(posedge mclk);
    sleep_exec <= 0;
    @(posedge mclk);
    chk(cpu_halt, 0);
    hw(2'h3, 3'h0, 3'h6, 2, 2'h2);
    hw(2'h3, 3'h2, 3'h6, 2, 2'h2);
    hw(2'h3, 3'h2, 3'h1, 60, 2'h0);
    hw(2'h3, 3'h4, 3'h1, 2, 2'h1);
    hw(2'h2, 3'h2, 3'h6, 60, 2'h0);
    hw(2'h2, 3'h3, 3'h6, 60, 2'h0);
    hw(2'h2, 3'h4, 3'h1, 2, 2'h1);
    hw(2'h2, 3'h4, 3'h6, 2, 2'h2);
    hw(2'h2, 3'h1, 3'h6, 2, 2'h1);
    hw(2'h3, 3'h5, 3'h6, 2, 2'h2);
    hw(2'h2, 3'h5, 3'h6, 60, 2'h0);
    hw(2'h2, 3'h6, 3'h6, 60, 2'h0);
    hw(2'h1, 3'h0, 3'h6, warm_test + 2, 2'h2);
    hw(2'h1, 3'h1, 3'h6, warm_test + 2, 2'h1);
    hw(2'h1, 3'h2, 3'h6, 60, 2'h0);
    end_sim;
  end
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end
endmodule
`default_nettype wire
